//--- hdl/ocd_cfg.svh
// Constants of the on-screen display command decoder and its host.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef OCD_CFG_SVH
`define OCD_CFG_SVH

// Opcode fields of the 16-bit command words
`define OCD_LVL_HI7      7'h48
`define OCD_LVL_LO6      6'h01
`define OCD_SIZE_OP4     4'ha
`define OCD_TEST_HI8     8'hb0
`define OCD_CHR_HI6      6'h30
`define OCD_END_CODE     8'hff
`define OCD_OFF_CODE     8'hfe

// Field positions in the upper byte, except OCD_SIZE_BIT in the lower byte
`define OCD_AMP_BIT      0
`define OCD_BLINK_BIT    1
`define OCD_ZERO_BIT     0
`define OCD_SIZE_BIT     0

// Luminance codes and levels
`define OCD_LUMA_75      2'h1
`define OCD_LUMA_90      2'h3
`define OCD_IRE_75       7'h4b
`define OCD_IRE_90       7'h5a
`define OCD_IRE_BG       7'h00

// Video RAM geometry
`define OCD_LINES        12
`define OCD_COLS         24
`define OCD_LAST_LINE    4'hb
`define OCD_LAST_COL     5'h17

// Scan lines per field for each character size
`define OCD_SCAN_SMALL   6'h09
`define OCD_SCAN_LARGE   6'h12

// Host register map (byte addresses)
`define OCD_REG_WORD     12'h000
`define OCD_REG_BYTE     12'h004
`define OCD_REG_STAT     12'h008
`define OCD_ST_BUSY      0
`define OCD_ST_OSC       1
`define OCD_ST_ERR       2
`define OCD_ST_ABBR      3

`endif

//--- hdl/ocd_pkg.sv
// Types shared by both ends of the display command link.
// Assumes ocd_cfg.svh for all numeric constants.
package ocd_pkg;

  typedef enum logic [1:0] {DEC_HI, DEC_LO, DEC_ABBR} ocd_dec_t;
  typedef enum logic [1:0] {TX_IDLE, TX_HI, TX_LO} ocd_tx_t;

  typedef struct packed {
    ocd_dec_t    mode;
    logic        abbr;
    logic [7:0]  hiByte;
    logic [1:0]  luma;
    logic        amp;
    logic        test;
    logic [11:0] lineSize;
    logic [3:0]  line;
    logic [4:0]  col;
    logic        blink;
    logic        wrEn;
    logic [8:0]  wrData;
    logic [8:0]  wrIdx;
    logic [2:0]  oscSync;
    logic        oscOn;
    logic [6:0]  charIre;
    logic [6:0]  bgIre;
    logic        sizeLarge;
    logic [5:0]  scanLines;
  } ocd_dev_t;

  typedef struct packed {
    ocd_tx_t     tx;
    logic [15:0] word;
    logic        abbr;
    logic        err;
    logic        stb;
    logic [7:0]  data;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } ocd_host_t;

endpackage : ocd_pkg

//--- hdl/ocd_link_if.sv
// Byte link between the command host and the display decoder.
// Assumes both ends run on the same clk_sys.
`timescale 1ns/10ps
interface ocd_link_if;
  logic       byteStb;   // One-cycle strobe, one byte
  logic [7:0] byteData;  // Byte carried with the strobe
  logic       oscRun;    // Dot oscillator running, from device

  modport dev  (input byteStb, input byteData, output oscRun);
  modport host (output byteStb, output byteData, input oscRun);
endinterface : ocd_link_if

//--- hdl/ocd_device.sv
// Display command decoder: output level, character size, test mode and
// display character commands, plus the 12 x 24 video RAM they fill.
// Assumes bytes arrive on the link on clk_sys, first byte = upper byte.
`timescale 1ns/10ps
`include "ocd_cfg.svh"

module ocd_device
  import ocd_pkg::*;
#(
  parameter int LINES = `OCD_LINES,
  parameter int COLS  = `OCD_COLS
) (
  input  wire logic       clk_sys,     // 20 MHz system clock
  input  wire logic       rst_n,       // Synchronous reset, active low
  ocd_link_if.dev         link,        // Byte link from the host
  input  wire logic       lcOscPin,    // Dot oscillator running (pin)
  input  wire logic       addrLoad,    // Load write address, pulse
  input  wire logic [3:0] addrLineIn,  // Write line to load
  input  wire logic [4:0] addrColIn,   // Write column to load
  input  wire logic [3:0] rdLine,      // Display read line
  input  wire logic [4:0] rdCol,       // Display read column
  output logic      [1:0] charLuma,    // Character luminance code
  output logic      [6:0] charIre,     // Character level in IRE
  output logic      [6:0] bgIre,       // Background level in IRE
  output logic            videoAmp,    // 0: 1 Vpp, 1: 2 Vpp
  output logic            testActive,  // Test mode engaged
  output logic            abbrMode,    // Byte-only character mode
  output logic      [3:0] wrLine,      // Current write line
  output logic      [4:0] wrCol,       // Current write column
  output logic      [7:0] rdCode,      // Code at read address
  output logic            rdBlink,     // Blink at read address
  output logic            rdBlank,     // Cell shows nothing
  output logic            rdSizeLarge, // Size of read line
  output logic      [5:0] rdScanLines  // Scan lines per field
);

  // -------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------
  ocd_dev_t s_r;
  ocd_dev_t s_nxt;

  // Blink in bit 8, code in bits 7..0
  logic [8:0] vram_r [LINES*COLS];
  logic [8:0] rdWord_r;
  logic       rdBlank_r;

  logic [15:0] word;
  logic        byteIn;
  logic        canWrite;

  assign byteIn   = link.byteStb;
  assign word     = {s_r.hiByte, link.byteData};
  assign canWrite = s_r.oscOn;

  // -------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------
  function automatic logic [8:0] cellIdx(input logic [3:0] ln,
                                         input logic [4:0] cl);
    cellIdx = 9'(ln * COLS + cl);
  endfunction : cellIdx

  // -------------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------------
  always_comb begin
    s_nxt         = s_r;
    s_nxt.wrEn    = 1'b0;
    // Three stages on the pin; a change counts once stages 2 and 3 agree
    s_nxt.oscSync = {s_r.oscSync[1:0], lcOscPin};
    if (s_r.oscSync[2] == s_r.oscSync[1]) begin
      s_nxt.oscOn = s_r.oscSync[2];
    end
    s_nxt.charIre = (s_r.luma == `OCD_LUMA_90) ? `OCD_IRE_90
                                               : `OCD_IRE_75;
    s_nxt.bgIre   = `OCD_IRE_BG;
    s_nxt.sizeLarge = s_r.lineSize[rdLine];
    s_nxt.scanLines = s_r.lineSize[rdLine] ? `OCD_SCAN_LARGE
                                           : `OCD_SCAN_SMALL;
    if (addrLoad) begin
      s_nxt.line = addrLineIn;
      s_nxt.col  = addrColIn;
    end
    if (byteIn) begin
      case (s_r.mode)
        DEC_HI: begin
          s_nxt.hiByte = link.byteData;
          s_nxt.mode   = DEC_LO;
        end
        DEC_LO: begin
          // Every word is decoded only once both bytes are in
          s_nxt.mode = DEC_HI;
          if (word[15:9] == `OCD_LVL_HI7 &&
              word[7:2] == `OCD_LVL_LO6) begin
            s_nxt.amp = word[8];
            // Only codes 01 and 11 are taken; 00 and 10 leave the luminance code as it was
            if (word[0]) begin
              s_nxt.luma = word[1:0];
            end
          end else if (word[15:12] == `OCD_SIZE_OP4) begin
            if (word[11:8] <= `OCD_LAST_LINE) begin
              s_nxt.lineSize[word[11:8]] =
                word[`OCD_SIZE_BIT];
            end
          end else if (word[15:8] == `OCD_TEST_HI8) begin
            s_nxt.test = (word[7:0] != 8'h00);
          end else if (word[15:10] == `OCD_CHR_HI6 &&
                       !word[8+`OCD_ZERO_BIT]) begin
            s_nxt.blink = word[8+`OCD_BLINK_BIT];
            s_nxt.mode  = DEC_ABBR;
            if (canWrite) begin
              s_nxt.wrEn   = 1'b1;
              s_nxt.wrIdx  = cellIdx(s_r.line, s_r.col);
              s_nxt.wrData = {word[8+`OCD_BLINK_BIT], word[7:0]};
            end
          end
        end
        DEC_ABBR: begin
          if (link.byteData == `OCD_END_CODE) begin
            s_nxt.mode = DEC_HI;
          end else if (canWrite) begin
            // FE goes in like any code and blanks on read
            s_nxt.wrEn   = 1'b1;
            s_nxt.wrIdx  = cellIdx(s_r.line, s_r.col);
            s_nxt.wrData = {s_r.blink, link.byteData};
          end
        end
        default: s_nxt.mode = DEC_HI;
      endcase
    end
    // Column advance after each stored character
    if (s_nxt.wrEn) begin
      if (s_r.col == `OCD_LAST_COL) begin
        s_nxt.col  = 5'h00;
        s_nxt.line = (s_r.line == `OCD_LAST_LINE) ? 4'h0
                                                  : s_r.line + 4'h1;
      end else begin
        s_nxt.col = s_r.col + 5'h01;
      end
    end
    // Byte mode kept as a flop so the output needs no decode
    s_nxt.abbr = (s_nxt.mode == DEC_ABBR);
  end

  // -------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_r           <= '0;
      s_r.mode      <= DEC_HI;
      s_r.luma      <= `OCD_LUMA_75;
      s_r.charIre   <= `OCD_IRE_75;
      s_r.scanLines <= `OCD_SCAN_SMALL;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Video RAM: one write port from the decoder, one read for display
  always_ff @(posedge clk_sys) begin
    if (s_r.wrEn) begin
      vram_r[s_r.wrIdx] <= s_r.wrData;
    end
    if (!rst_n) begin
      rdWord_r  <= 9'h000;
      rdBlank_r <= 1'b0;
    end else if (rdLine <= `OCD_LAST_LINE && rdCol <= `OCD_LAST_COL) begin
      rdWord_r  <= vram_r[cellIdx(rdLine, rdCol)];
      rdBlank_r <= (vram_r[cellIdx(rdLine, rdCol)][7:0] == `OCD_OFF_CODE);
    end else begin
      rdWord_r  <= 9'h000;
      rdBlank_r <= 1'b0;
    end
  end

  // -------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------
  assign link.oscRun = s_r.oscOn;
  assign charLuma    = s_r.luma;
  assign charIre     = s_r.charIre;
  assign bgIre       = s_r.bgIre;
  assign videoAmp    = s_r.amp;
  assign testActive  = s_r.test;
  assign abbrMode    = s_r.abbr;
  assign wrLine      = s_r.line;
  assign wrCol       = s_r.col;
  assign rdCode      = rdWord_r[7:0];
  assign rdBlink     = rdWord_r[8];
  assign rdBlank     = rdBlank_r;
  assign rdSizeLarge = s_r.sizeLarge;
  assign rdScanLines = s_r.scanLines;

endmodule : ocd_device

//--- hdl/ocd_host.sv
// Host end: takes command words from software over APB and sends them
// as byte pairs, or single bytes in character byte mode, on the link.
// Assumes the device and this end share clk_sys.
`timescale 1ns/10ps
`include "ocd_cfg.svh"

module ocd_host
  import ocd_pkg::*;
(
  input  wire logic        clk_sys,  // 20 MHz system clock
  input  wire logic        rst_n,    // Synchronous reset, active low
  ocd_link_if.host         link,     // Byte link to the device
  input  wire logic        psel,     // APB select
  input  wire logic        penable,  // APB access phase
  input  wire logic        pwrite,   // APB write
  input  wire logic [11:0] paddr,    // APB byte address
  input  wire logic [31:0] pwdata,   // APB write data
  output logic      [31:0] prdata,   // APB read data
  output logic             pready,   // APB ready
  output logic             pslverr   // APB error
);

  ocd_host_t s_r;
  ocd_host_t s_nxt;

  logic        setup;
  logic        wr;
  logic [15:0] w;
  logic        bad;

  // Answer is prepared in the setup cycle, ready on first access cycle
  assign setup = psel && !penable;
  assign wr    = psel && penable && pwrite && s_r.pready;
  assign w     = pwdata[15:0];

  // -------------------------------------------------------------------
  // Checks on what software asks to send
  // -------------------------------------------------------------------
  always_comb begin
    bad = 1'b0;
    if (paddr == `OCD_REG_WORD) begin
      if (w[15:9] == `OCD_LVL_HI7 && w[7:2] == `OCD_LVL_LO6) begin
        bad = !w[0];
      end else if (w[15:8] == `OCD_TEST_HI8) begin
        bad = (w[7:0] != 8'h00);
      end else if (w[15:10] == `OCD_CHR_HI6) begin
        bad = !link.oscRun;
      end
    end else if (paddr == `OCD_REG_BYTE) begin
      // Bare bytes only follow a character word
      bad = !s_r.abbr || (!link.oscRun &&
            pwdata[7:0] != `OCD_END_CODE);
    end
    bad = bad || (pwrite && s_r.tx != TX_IDLE &&
                  paddr != `OCD_REG_STAT);
  end

  always_comb begin
    s_nxt        = s_r;
    s_nxt.stb    = 1'b0;
    s_nxt.pready = setup;
    if (setup) begin
      s_nxt.pslverr = pwrite && bad;
      s_nxt.prdata  = 32'h0000_0000;
      if (!pwrite && paddr == `OCD_REG_STAT) begin
        s_nxt.prdata[`OCD_ST_BUSY] = (s_r.tx != TX_IDLE);
        s_nxt.prdata[`OCD_ST_OSC]  = link.oscRun;
        s_nxt.prdata[`OCD_ST_ERR]  = s_r.err;
        s_nxt.prdata[`OCD_ST_ABBR] = s_r.abbr;
      end else if (!pwrite && paddr != `OCD_REG_WORD &&
                   paddr != `OCD_REG_BYTE) begin
        s_nxt.pslverr = 1'b1;
      end
      if (pwrite && paddr != `OCD_REG_WORD && paddr != `OCD_REG_BYTE &&
          paddr != `OCD_REG_STAT) begin
        s_nxt.pslverr = 1'b1;
      end
    end
    // Software clears the error bit by writing one to it
    if (wr && paddr == `OCD_REG_STAT && pwdata[`OCD_ST_ERR]) begin
      s_nxt.err = 1'b0;
    end
    if (wr && paddr != `OCD_REG_STAT) begin
      if (s_r.pslverr) begin
        s_nxt.err = 1'b1;
      end else if (paddr == `OCD_REG_WORD) begin
        s_nxt.word = w;
        s_nxt.tx   = TX_HI;
        s_nxt.abbr = (w[15:10] == `OCD_CHR_HI6);
      end else begin
        s_nxt.stb  = 1'b1;
        s_nxt.data = pwdata[7:0];
        if (pwdata[7:0] == `OCD_END_CODE) begin
          s_nxt.abbr = 1'b0;
        end
      end
    end
    case (s_r.tx)
      TX_IDLE: ;
      TX_HI: begin
        s_nxt.stb  = 1'b1;
        s_nxt.data = s_r.word[15:8];
        s_nxt.tx   = TX_LO;
      end
      TX_LO: begin
        s_nxt.stb  = 1'b1;
        s_nxt.data = s_r.word[7:0];
        s_nxt.tx   = TX_IDLE;
      end
      default: s_nxt.tx = TX_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_r    <= '0;
      s_r.tx <= TX_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.byteStb  = s_r.stb;
  assign link.byteData = s_r.data;
  assign prdata        = s_r.prdata;
  assign pready        = s_r.pready;
  assign pslverr       = s_r.pslverr;

endmodule : ocd_host

//--- verif/ocd_link_checker.sv
// Assertions on the byte link and on the decoder's settings outputs.
// Assumes the testbench wires it beside the link; one clock domain.
`timescale 1ns/10ps
`include "ocd_cfg.svh"

module ocd_link_checker (
  input wire logic       clk_sys,    // System clock
  input wire logic       rst_n,      // Synchronous reset, active low
  input wire logic       byteStb,    // Link byte strobe
  input wire logic [7:0] byteData,   // Link byte
  input wire logic       oscRun,     // Dot oscillator running
  input wire logic       addrLoad,   // Write address load
  input wire logic [1:0] charLuma,   // Luminance code
  input wire logic [6:0] charIre,    // Character level
  input wire logic [6:0] bgIre,      // Background level
  input wire logic       videoAmp,   // Amplitude select
  input wire logic       testActive, // Test mode
  input wire logic       abbrMode,   // Byte-only mode
  input wire logic [3:0] wrLine,     // Write line
  input wire logic [4:0] wrCol       // Write column
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Word shapes as seen on the link
  // ----------------------------------------------------------------
  sequence s_lvl;
    !abbrMode && byteStb && byteData[7:1] == `OCD_LVL_HI7
    ##1 byteStb && byteData[7:2] == `OCD_LVL_LO6;
  endsequence
  sequence s_test;
    !abbrMode && byteStb && byteData == `OCD_TEST_HI8 ##1 byteStb;
  endsequence
  sequence s_chr;
    !abbrMode && byteStb && byteData[7:2] == `OCD_CHR_HI6
    && !byteData[`OCD_ZERO_BIT] ##1 byteStb;
  endsequence

  AST_BG_ZERO: assert property (bgIre == `OCD_IRE_BG)
    else $error("background level not zero");
  AST_IRE_MAP: assert property (
    1'b1 |=> charIre == ($past(charLuma) == `OCD_LUMA_90 ?
                         `OCD_IRE_90 : `OCD_IRE_75))
    else $error("character level does not follow luminance code");
  AST_LUMA_LEGAL: assert property (
    charLuma == `OCD_LUMA_75 || charLuma == `OCD_LUMA_90)
    else $error("luminance code took an illegal value");
  AST_LVL_AMP: assert property (
    s_lvl |=> videoAmp == $past(byteData[`OCD_AMP_BIT], 2))
    else $error("amplitude not taken from upper byte");
  AST_LVL_LUMA: assert property (
    s_lvl ##0 byteData[0] |=> charLuma == $past(byteData[1:0]))
    else $error("luminance not taken from lower byte");
  AST_TEST_CLR: assert property (
    s_test |=> testActive == ($past(byteData) != 8'h00))
    else $error("test mode flag wrong after test word");
  AST_ABBR_ON: assert property (s_chr |=> abbrMode)
    else $error("byte mode not entered after character word");
  AST_ABBR_END: assert property (
    abbrMode && byteStb && byteData == `OCD_END_CODE |=> !abbrMode)
    else $error("end code did not leave byte mode");
  AST_COL_STEP: assert property (
    !$past(addrLoad) && wrCol != $past(wrCol)
    && $past(wrCol) != `OCD_LAST_COL |-> wrCol == $past(wrCol) + 5'h01)
    else $error("write column did not step by one");
  AST_COL_WRAP: assert property (
    !$past(addrLoad) && $past(wrCol) == `OCD_LAST_COL
    && wrCol != `OCD_LAST_COL |-> wrCol == 5'h00 && wrLine ==
    ($past(wrLine) == `OCD_LAST_LINE ? 4'h0 : $past(wrLine) + 4'h1))
    else $error("write column did not wrap to next line");
  AST_ADDR_RANGE: assert property (
    wrCol <= `OCD_LAST_COL && wrLine <= `OCD_LAST_LINE)
    else $error("write address outside the video memory");
  CV_BYTE_MODE: cover property (oscRun && abbrMode);
endmodule : ocd_link_checker

//--- verif/testbench.sv
// Self-checking bench: host and decoder joined by the byte link, with
// software orders given over APB. Assumes ocd_cfg.svh on include path.
`timescale 1ns/10ps
`include "ocd_cfg.svh"

module testbench;
  typedef struct packed {
    logic       amp;
    logic [1:0] luma;
    logic [6:0] ire;
  } ocd_lvl_t;
  typedef struct packed {
    logic [3:0] line;
    logic [4:0] col;
    logic       bl;
    logic [7:0] code;
  } ocd_cell_t;

  logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        lcOscPin, addrLoad, videoAmp, testActive, abbrMode, e;
  logic        rdBlink, rdBlank, rdSizeLarge;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, ex, st;
  logic [3:0]  addrLineIn, rdLine, wrLine;
  logic [4:0]  addrColIn, rdCol, wrCol;
  logic [1:0]  charLuma;
  logic [6:0]  charIre, bgIre;
  logic [7:0]  rdCode;
  logic [5:0]  rdScanLines;
  logic [16:0] lvlNow;
  int          n_fail, compares;
  ocd_lvl_t    lvlRows [4] = '{{1'b0, `OCD_LUMA_90, `OCD_IRE_90},
    {1'b1, `OCD_LUMA_75, `OCD_IRE_75}, {1'b0, `OCD_LUMA_75, `OCD_IRE_75},
    {1'b1, `OCD_LUMA_90, `OCD_IRE_90}};
  ocd_cell_t   cells [4] = '{{4'hb, 5'h16, 1'b1, 8'h41},
    {4'hb, 5'h17, 1'b1, 8'h42}, {4'h0, 5'h00, 1'b1, `OCD_OFF_CODE},
    {4'h0, 5'h01, 1'b0, 8'h30}};

  assign lvlNow = {charLuma, charIre, bgIre, videoAmp};

  ocd_link_if link ();
  ocd_host i_ocd_host (.clk_sys(clk_sys), .rst_n(rst_n), .link(link.host),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  ocd_device i_ocd_device (.clk_sys(clk_sys), .rst_n(rst_n),
    .link(link.dev), .lcOscPin(lcOscPin), .addrLoad(addrLoad),
    .addrLineIn(addrLineIn), .addrColIn(addrColIn), .rdLine(rdLine),
    .rdCol(rdCol), .charLuma(charLuma), .charIre(charIre), .bgIre(bgIre),
    .videoAmp(videoAmp), .testActive(testActive), .abbrMode(abbrMode),
    .wrLine(wrLine), .wrCol(wrCol), .rdCode(rdCode), .rdBlink(rdBlink),
    .rdBlank(rdBlank), .rdSizeLarge(rdSizeLarge),
    .rdScanLines(rdScanLines));
  ocd_link_checker i_ocd_link_checker (.clk_sys(clk_sys), .rst_n(rst_n),
    .byteStb(link.byteStb), .byteData(link.byteData),
    .oscRun(link.oscRun), .addrLoad(addrLoad), .charLuma(charLuma),
    .charIre(charIre), .bgIre(bgIre), .videoAmp(videoAmp),
    .testActive(testActive), .abbrMode(abbrMode), .wrLine(wrLine),
    .wrCol(wrCol));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // Bus and check helpers
  // ----------------------------------------------------------------
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  task automatic fail(input string what);
    n_fail++;
    $display("ERROR %s expected answer seen timeout", what);
    test_done();
  endtask : fail

  task automatic chk(input string name, input logic [31:0] exv,
                     input logic [31:0] got);
    compares++;
    if (got !== exv) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exv, got);
    end
  endtask : chk

  // Request held until pready is seen high at a rising edge; the answer
  // is taken and the request released at that same edge.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    int i;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    if (i == 20) fail("pready");
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic idle;
    int i;
    for (i = 0; i < 20; i++) begin
      apb(1'b0, `OCD_REG_STAT, 32'h0, q, e);
      if (q[`OCD_ST_BUSY] === 1'b0) break;
    end
    if (i == 20) fail("busy");
    st = q;
  endtask : idle

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic ee);
    apb(1'b1, a, d, q, e);
    chk("pslverr", {31'h0, ee}, {31'h0, e});
    idle();
  endtask : wr

  task automatic wait_osc(input logic v);
    int i;
    for (i = 0; i < 50; i++) begin
      @(negedge clk_sys);
      if (link.oscRun === v) break;
    end
    if (i == 50) fail("oscRun");
  endtask : wait_osc

  task automatic look(input logic [3:0] l, input logic [4:0] c);
    @(posedge clk_sys);
    rdLine <= l;
    rdCol  <= c;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : look

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, addrLoad, rst_n} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    lcOscPin = 1'b1;
    {addrLineIn, addrColIn, rdLine, rdCol} = 18'h0;
    n_fail = 0;
    compares = 0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    wait_osc(1'b1);
    ex = {15'h0, `OCD_LUMA_75, `OCD_IRE_75, `OCD_IRE_BG, 1'b0};
    chk("level", ex, {15'h0, lvlNow});
    chk("modes", 32'h0, {21'h0, testActive, abbrMode, wrLine, wrCol});
    for (int k = 0; k < 4; k++) begin
      wr(`OCD_REG_WORD, {16'h0, `OCD_LVL_HI7, lvlRows[k].amp,
         `OCD_LVL_LO6, lvlRows[k].luma}, 1'b0);
      ex = {15'h0, lvlRows[k].luma, lvlRows[k].ire, `OCD_IRE_BG,
            lvlRows[k].amp};
      chk("level", ex, {15'h0, lvlNow});
    end
    // Prohibited code is refused and the old setting kept
    wr(`OCD_REG_WORD, {16'h0, `OCD_LVL_HI7, 1'b0, `OCD_LVL_LO6, 2'h2},
       1'b1);
    chk("level", ex, {15'h0, lvlNow});
    chk("errBit", 32'h1, {31'h0, st[`OCD_ST_ERR]});
    wr(`OCD_REG_STAT, 32'h4, 1'b0);
    chk("errBit", 32'h0, {31'h0, st[`OCD_ST_ERR]});
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    wait_osc(1'b1);
    ex = {15'h0, `OCD_LUMA_75, `OCD_IRE_75, `OCD_IRE_BG, 1'b0};
    chk("level", ex, {15'h0, lvlNow});
    for (int k = 0; k < 12; k += 11) begin
      wr(`OCD_REG_WORD, {16'h0, `OCD_SIZE_OP4, k[3:0], 8'h01},
         1'b0);
    end
    for (int k = 0; k < 12; k++) begin
      look(k[3:0], 5'h00);
      ex = (k == 0 || k == 11) ? {25'h0, 1'b1, `OCD_SCAN_LARGE}
                              : {25'h0, 1'b0, `OCD_SCAN_SMALL};
      chk("size", ex,
          {25'h0, rdSizeLarge, rdScanLines});
    end
    wr(`OCD_REG_WORD, {16'h0, `OCD_TEST_HI8, 8'h00}, 1'b0);
    wr(`OCD_REG_WORD, {16'h0, `OCD_TEST_HI8, 8'h5a}, 1'b1);
    chk("testActive", 32'h0, {31'h0, testActive});
    @(posedge clk_sys);
    addrLoad   <= 1'b1;
    addrLineIn <= `OCD_LAST_LINE;
    addrColIn  <= 5'h16;
    @(posedge clk_sys);
    addrLoad   <= 1'b0;
    wr(`OCD_REG_WORD, {16'h0, `OCD_CHR_HI6, 2'h2, 8'h41}, 1'b0);
    chk("abbrMode", 32'h1, {31'h0, abbrMode});
    wr(`OCD_REG_BYTE, 32'h42, 1'b0);
    wr(`OCD_REG_BYTE, {24'h0, `OCD_OFF_CODE}, 1'b0);
    wr(`OCD_REG_BYTE, {24'h0, `OCD_END_CODE}, 1'b0);
    wr(`OCD_REG_WORD, {16'h0, `OCD_CHR_HI6, 2'h0, 8'h30}, 1'b0);
    wr(`OCD_REG_BYTE, {24'h0, `OCD_END_CODE}, 1'b0);
    chk("addr", 32'h2, {22'h0, abbrMode, wrLine, wrCol});
    wr(`OCD_REG_BYTE, 32'h43, 1'b1);
    for (int k = 0; k < 4; k++) begin
      look(cells[k].line, cells[k].col);
      ex = {22'h0, cells[k].bl, cells[k].code == `OCD_OFF_CODE,
            cells[k].code};
      chk("cell", ex, {22'h0, rdBlink, rdBlank,
          rdCode});
    end
    // Stopped oscillator: character word refused, address kept
    @(posedge clk_sys);
    lcOscPin <= 1'b0;
    wait_osc(1'b0);
    wr(`OCD_REG_WORD, {16'h0, `OCD_CHR_HI6, 2'h0, 8'h55}, 1'b1);
    chk("addr", 32'h2, {22'h0, abbrMode, wrLine, wrCol});
    @(posedge clk_sys);
    lcOscPin <= 1'b1;
    wait_osc(1'b1);
    apb(1'b0, 12'h00c, 32'h0, q, e);
    chk("pslverr", 32'h1, {31'h0, e});
    test_done();
  end
endmodule : testbench
